/* File: rtl/pss_consts.svh */
// Timing, sizing and reset constants of the power switch-on supervisor
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

// Clock rate in MHz, cycles per microsecond
`define PSS_CLK_MHZ            250

// Minimum toggle interval in us: nominal, lower and upper bound
`define PSS_MIN_INTERVAL_US    360000
`define PSS_MIN_INTERVAL_LO_US 327000
`define PSS_MIN_INTERVAL_HI_US 400000

// Maximum toggle interval in us: nominal, lower and upper bound
`define PSS_MAX_INTERVAL_US    2860000
`define PSS_MAX_INTERVAL_LO_US 2600000
`define PSS_MAX_INTERVAL_HI_US 3178000

// Startup response timer length in us
`define PSS_RESP_US            500000

// Time allowed for one supply block to report good, in us
`define PSS_STEP_TIMEOUT_US    100

// Number of supply blocks brought up in sequence
`define PSS_NUM_SUPPLY         4

// Width of the shared interval timer
`define PSS_TIMER_W            32

// Reset value of the synchronizer stages
`define PSS_SYNC_RST           1'b0

`endif

/* File: rtl/pss_pkg.sv */
// Types of the power switch-on supervisor
package pss_pkg;

    typedef enum logic [2:0] {
        ST_INIT,
        ST_OFF,
        ST_SEQ,
        ST_WAIT,
        ST_ACTIVE
    } pss_state_type;

endpackage

/* File: rtl/pss_sync.sv */
// Two-stage synchronizer for asynchronous pin inputs
`timescale 1ns/1ps
`include "pss_consts.svh"

module pss_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stage1_reg <= {WIDTH{`PSS_SYNC_RST}};
            stage2_reg <= {WIDTH{`PSS_SYNC_RST}};
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule

/* File: rtl/pss_top.sv */
// Switch-on detection, supply sequencing and toggle watchdog supervisor
`timescale 1ns/1ps
`include "pss_consts.svh"

// Overview of operation
// - Start on charger, key fall, aux rise
// - Charger level at reset end, edges afterwards
// - Switch-on sources never block each other
// - Supplies enabled in order, each checked
// - Any start-up failure returns to power down
// - First watchdog rise in timer arms supervision
// - First watchdog fall powers everything down
// - Every watchdog edge reloads interval counter
// - Edge too early or too late: power down
// - Minimum interval nominal 0,360 s
// - Maximum interval nominal 2,860 s
// - After reset: reference, oscillator, fuses, off
// - Supply below threshold: synchronous reset, off
// - Start-up stops on under/overvoltage or timeout
// - Reset output rises once the last supply block is good
module pss_top
    import pss_pkg::*;
#(
    parameter int NUM_SUPPLY      = `PSS_NUM_SUPPLY,
    parameter int MIN_TOGGLE_CYC  = `PSS_MIN_INTERVAL_US * `PSS_CLK_MHZ,
    parameter int MAX_TOGGLE_CYC  = `PSS_MAX_INTERVAL_US * `PSS_CLK_MHZ,
    parameter int RESP_CYC        = `PSS_RESP_US * `PSS_CLK_MHZ,
    parameter int STEP_TIMEOUT_CYC = `PSS_STEP_TIMEOUT_US * `PSS_CLK_MHZ
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    // Switch-on pins
    input  wire logic                  key_n,
    input  wire logic                  aux_switch_on_input,
    input  wire logic                  charger_supply_level,
    // Watchdog pin
    input  wire logic                  watchdog_toggle_input,
    // Analog monitors
    input  wire logic                  por_low,
    input  wire logic                  undervoltage,
    input  wire logic                  overvoltage,
    input  wire logic                  fuses_loaded,
    input  wire logic [NUM_SUPPLY-1:0] block_good,
    // Control outputs
    output logic      [NUM_SUPPLY-1:0] supply_en,
    output logic                       secondary_reset_output,
    output logic                       ref_osc_en,
    output logic                       fuse_read,
    // Status outputs
    output logic                       powered_down,
    output logic                       phone_active,
    output logic                       shutdown_pulse
);

    localparam int TW    = `PSS_TIMER_W;
    localparam int IDX_W = (NUM_SUPPLY > 1) ? $clog2(NUM_SUPPLY) : 1;

    function automatic logic edge_det(input logic cur, input logic prev, input logic rising);
        return rising ? (cur & ~prev) : (~cur & prev);
    endfunction

    function automatic logic timer_at(input logic [TW-1:0] t, input int limit);
        return t == TW'(limit - 1);
    endfunction

    pss_state_type             state_reg;
    pss_state_type             state_next;
    logic [TW-1:0]             timer_reg;
    logic [TW-1:0]             timer_next;
    logic [IDX_W-1:0]          idx_reg;
    logic [IDX_W-1:0]          idx_next;
    logic [NUM_SUPPLY-1:0]     supply_en_reg;
    logic [NUM_SUPPLY-1:0]     supply_en_next;
    logic                      rst_out_reg;
    logic                      rst_out_next;
    logic                      ref_osc_reg;
    logic                      fuse_read_reg;
    logic                      down_reg;
    logic                      active_reg;
    logic                      shut_reg;
    logic                      key_pend_reg;
    logic                      aux_pend_reg;
    logic                      chg_pend_reg;
    logic [3:0]                prev_reg;

    logic [3:0] pins_sync;
    pss_sync #(
        .WIDTH(4)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .async_in ({watchdog_toggle_input, charger_supply_level, aux_switch_on_input, key_n}),
        .sync_out (pins_sync)
    );

    wire key_s = pins_sync[0];
    wire aux_s = pins_sync[1];
    wire chg_s = pins_sync[2];
    wire wd_s  = pins_sync[3];

    wire in_init   = (state_reg == ST_INIT);
    wire in_off    = (state_reg == ST_OFF);
    wire init_done = in_init & fuses_loaded;
    // Switch-on edges count only once initialization has settled
    wire edges_ok  = ~in_init;
    wire key_fall  = edges_ok & edge_det(key_s, prev_reg[0], 1'b0);
    wire aux_rise  = edges_ok & edge_det(aux_s, prev_reg[1], 1'b1);
    wire chg_rise  = edges_ok & edge_det(chg_s, prev_reg[2], 1'b1);
    wire wd_rise   = edge_det(wd_s, prev_reg[3], 1'b1);
    wire wd_fall   = edge_det(wd_s, prev_reg[3], 1'b0);
    wire wd_edge   = wd_rise | wd_fall;

    wire start_req = key_pend_reg | aux_pend_reg | chg_pend_reg;
    wire start_go  = in_off & start_req & ~por_low;
    // Level capture at end of reset, edge afterwards
    wire chg_set   = chg_rise | (init_done & chg_s);

    wire step_good    = block_good[idx_reg];
    wire step_last    = (idx_reg == IDX_W'(NUM_SUPPLY - 1));
    wire step_timeout = timer_at(timer_reg, STEP_TIMEOUT_CYC);
    wire resp_expired = timer_at(timer_reg, RESP_CYC);
    wire too_early    = timer_reg < TW'(MIN_TOGGLE_CYC - 1);
    wire too_late     = timer_at(timer_reg, MAX_TOGGLE_CYC);
    wire [NUM_SUPPLY-1:0] supply_grow;
    assign supply_grow = NUM_SUPPLY'({supply_en_reg, 1'b1});

    always_comb begin
        state_next     = state_reg;
        timer_next     = timer_reg + TW'(1);
        idx_next       = idx_reg;
        supply_en_next = supply_en_reg;
        rst_out_next   = rst_out_reg;
        case (state_reg)
            // Wait for fuse read, then power down
            ST_INIT: begin
                timer_next = '0;
                if (fuses_loaded) begin
                    state_next = ST_OFF;
                end
            end
            ST_OFF: begin
                timer_next = '0;
                if (start_req) begin
                    state_next     = ST_SEQ;
                    idx_next       = '0;
                    supply_en_next = NUM_SUPPLY'(1);
                end
            end
            ST_SEQ: begin
                if (undervoltage | overvoltage) begin
                    state_next = ST_OFF;
                end else if (step_good) begin
                    timer_next = '0;
                    if (step_last) begin
                        state_next   = ST_WAIT;
                        rst_out_next = 1'b1;
                    end else begin
                        idx_next       = idx_reg + IDX_W'(1);
                        supply_en_next = supply_grow;
                    end
                end else if (step_timeout) begin
                    state_next = ST_OFF;
                end
            end
            ST_WAIT: begin
                if (undervoltage | overvoltage) begin
                    state_next = ST_OFF;
                end else if (wd_rise) begin
                    state_next = ST_ACTIVE;
                    timer_next = '0;
                end else if (wd_fall) begin
                    state_next = ST_OFF;
                end else if (resp_expired) begin
                    state_next = ST_OFF;
                end
            end
            ST_ACTIVE: begin
                if (overvoltage) begin
                    state_next = ST_OFF;
                end else if (wd_edge) begin
                    if (too_early) begin
                        state_next = ST_OFF;
                    end else begin
                        timer_next = '0;
                    end
                end else if (too_late) begin
                    state_next = ST_OFF;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        if (por_low) begin
            state_next = (state_reg == ST_INIT) ? ST_INIT : ST_OFF;
        end
        if (state_next == ST_OFF || state_next == ST_INIT) begin
            timer_next     = '0;
            idx_next       = '0;
            supply_en_next = '0;
            rst_out_next   = 1'b0;
        end
    end

    wire leaving_on = (state_next == ST_OFF) & ~in_off & ~in_init;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg     <= ST_INIT;
            timer_reg     <= '0;
            idx_reg       <= '0;
            supply_en_reg <= '0;
            rst_out_reg   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            timer_reg     <= timer_next;
            idx_reg       <= idx_next;
            supply_en_reg <= supply_en_next;
            rst_out_reg   <= rst_out_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ref_osc_reg   <= 1'b0;
            fuse_read_reg <= 1'b0;
            down_reg      <= 1'b1;
            active_reg    <= 1'b0;
            shut_reg      <= 1'b0;
            prev_reg      <= 4'h0;
        end else begin
            ref_osc_reg   <= 1'b1;
            fuse_read_reg <= (state_next == ST_INIT);
            down_reg      <= (state_next == ST_OFF) | (state_next == ST_INIT);
            active_reg    <= (state_next == ST_ACTIVE);
            shut_reg      <= leaving_on;
            prev_reg      <= pins_sync;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            key_pend_reg <= 1'b0;
            aux_pend_reg <= 1'b0;
            chg_pend_reg <= 1'b0;
        end else if (por_low) begin
            key_pend_reg <= 1'b0;
            aux_pend_reg <= 1'b0;
            chg_pend_reg <= 1'b0;
        end else begin
            key_pend_reg <= (key_fall & (in_off | in_init)) | (key_pend_reg & ~start_go);
            aux_pend_reg <= (aux_rise & (in_off | in_init)) | (aux_pend_reg & ~start_go);
            chg_pend_reg <= (chg_set & (in_off | in_init)) | (chg_pend_reg & ~start_go);
        end
    end

    assign supply_en              = supply_en_reg;
    assign secondary_reset_output = rst_out_reg;
    assign ref_osc_en             = ref_osc_reg;
    assign fuse_read              = fuse_read_reg;
    assign powered_down           = down_reg;
    assign phone_active           = active_reg;
    assign shutdown_pulse         = shut_reg;

    early_edge_off_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg == ST_ACTIVE) && wd_edge && too_early |=> (state_reg == ST_OFF) && shutdown_pulse)
        else $error("early watchdog edge did not power down");

    max_interval_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg == ST_ACTIVE) |-> timer_reg < TW'(MAX_TOGGLE_CYC))
        else $error("watchdog interval exceeded maximum");

    first_fall_off_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg == ST_WAIT) && wd_fall && !wd_rise |=> state_reg == ST_OFF)
        else $error("first falling edge did not power down");

    arm_on_rise_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg == ST_WAIT) && wd_rise && !undervoltage && !overvoltage && !por_low
        |=> (state_reg == ST_ACTIVE) && (timer_reg == '0) && phone_active)
        else $error("first rising edge did not arm supervision");

    edge_reload_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg == ST_ACTIVE) && wd_edge && !too_early && !overvoltage && !por_low
        |=> (state_reg == ST_ACTIVE) && (timer_reg == '0))
        else $error("valid watchdog edge did not reload counter");

    resp_bound_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg == ST_WAIT) |-> timer_reg < TW'(RESP_CYC))
        else $error("response timer ran past its limit");

    reset_release_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        $rose(secondary_reset_output) |-> ($past(state_reg) == ST_SEQ) && (state_reg == ST_WAIT)
        && (supply_en_reg == {NUM_SUPPLY{1'b1}}))
        else $error("reset output released outside sequence end");

    seq_order_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        $changed(supply_en_reg) && (supply_en_reg != '0) |-> supply_en_reg == $past(supply_grow))
        else $error("supply blocks enabled out of order");

    seq_fail_off_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg == ST_SEQ) && (undervoltage || overvoltage) |=> (state_reg == ST_OFF) && (supply_en_reg == '0))
        else $error("start-up failure did not abort");

    por_low_off_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        por_low && !in_init |=> (state_reg == ST_OFF) && !secondary_reset_output && (supply_en_reg == '0))
        else $error("supply low did not force power down");

    start_any_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        in_off && start_req && !por_low |=> (state_reg == ST_SEQ) && (supply_en_reg == NUM_SUPPLY'(1)))
        else $error("pending switch-on condition did not start");

    charger_level_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        init_done && chg_s && !por_low |=> chg_pend_reg)
        else $error("charger level at reset end was missed");

endmodule

/* File: tb/pss_host_model.sv */
// Host and supply block model facing the switch-on supervisor
`timescale 1ns/1ps
module pss_host_model #(
    parameter int NS      = 4,
    parameter int MIN_CYC = 20
) (
    // Clock and device outputs
    input  wire logic          sys_clk,
    input  wire logic          secondary_reset_output,
    input  wire logic [NS-1:0] supply_en,
    // Scenario controls
    input  wire logic [NS-1:0] good_mask,
    input  wire logic          fall_first,
    input  wire logic          early,
    input  wire logic signed [31:0] first_gap,
    input  wire logic signed [31:0] gap,
    input  wire logic signed [31:0] n_tog,
    // Pins towards the device
    output logic               watchdog_toggle_input,
    output logic      [NS-1:0] block_good,
    output logic               tog_done
);
    logic [NS-1:0] en_d1 = '0;
    logic [NS-1:0] en_d2 = '0;
    int            wait_cyc;

    // Blocks report good two cycles after enable
    always @(negedge sys_clk) begin
        en_d1 <= supply_en;
        en_d2 <= en_d1;
    end
    assign block_good = en_d2 & ~good_mask;

    initial begin
        watchdog_toggle_input = 1'b0;
        tog_done = 1'b0;
        forever begin
            @(negedge sys_clk);
            tog_done = 1'b0;
            if (secondary_reset_output !== 1'b1) begin
                watchdog_toggle_input = fall_first;
            end else begin
                for (int i = 0; i < n_tog; i++) begin
                    wait_cyc = (i == 0) ? first_gap : ((early && i == n_tog - 1) ? MIN_CYC - 5 : gap);
                    // Give up the wait as soon as the reset output drops
                    for (int c = 0; c < wait_cyc && secondary_reset_output === 1'b1; c++) begin
                        @(negedge sys_clk);
                    end
                    if (secondary_reset_output !== 1'b1) break;
                    watchdog_toggle_input = ~watchdog_toggle_input;
                end
                tog_done = 1'b1;
                wait (secondary_reset_output !== 1'b1);
            end
        end
    end
endmodule

/* File: tb/pss_tb_top.sv */
// Self-checking bench of the switch-on supervisor
`timescale 1ns/1ps
module pss_tb_top;
    localparam int NS = 4, MIN = 20, MAX = 100, RESP = 200, STEP = 10;
    logic          sys_clk = 1'b0;
    logic          rstn    = 1'b0;
    logic [2:0]    pins    = 3'h5;
    logic          por_low = 1'b0;
    logic          uv      = 1'b0;
    logic          ov      = 1'b0;
    logic          fuses   = 1'b0;
    logic          wd;
    logic [NS-1:0] block_good;
    logic [NS-1:0] supply_en;
    logic          secondary_reset_output;
    logic          ref_osc_en;
    logic          fuse_read;
    logic          powered_down;
    logic          phone_active;
    logic          shutdown_pulse;
    logic          tog_done;
    logic [NS-1:0] good_mask = '0;
    logic          fall_first = 1'b0;
    logic          early = 1'b0;
    int            first_gap = 0;
    int            gap = 0;
    int            n_tog = 0;
    int            num_errors = 0;
    int            checked = 0;
    int            cyc = 0;
    logic [31:0]   lfsr_reg = 32'h0000_7928;
    logic [NS-1:0] sup_prev = '0;
    logic          pd_prev = 1'b1;
    logic          rso_prev = 1'b0;
    logic          sp_prev = 1'b0;

    pss_top #(.MIN_TOGGLE_CYC(MIN), .MAX_TOGGLE_CYC(MAX), .RESP_CYC(RESP), .STEP_TIMEOUT_CYC(STEP)) i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .key_n(pins[0]), .aux_switch_on_input(pins[1]),
        .charger_supply_level(pins[2]), .watchdog_toggle_input(wd), .por_low(por_low),
        .undervoltage(uv), .overvoltage(ov), .fuses_loaded(fuses), .block_good(block_good),
        .supply_en(supply_en), .secondary_reset_output(secondary_reset_output), .ref_osc_en(ref_osc_en),
        .fuse_read(fuse_read), .powered_down(powered_down), .phone_active(phone_active),
        .shutdown_pulse(shutdown_pulse));

    pss_host_model #(.NS(NS), .MIN_CYC(MIN)) i_host (
        .sys_clk(sys_clk), .secondary_reset_output(secondary_reset_output), .supply_en(supply_en),
        .good_mask(good_mask), .fall_first(fall_first), .early(early), .first_gap(first_gap), .gap(gap),
        .n_tog(n_tog), .watchdog_toggle_input(wd), .block_good(block_good), .tog_done(tog_done));

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 10000) begin
            num_errors++;
            $display("ERROR run_length expected below 10000 seen %0d", cyc);
            results();
        end
    end

    // Next enable pattern: one more block from bit 0 upward
    function automatic logic [NS-1:0] exp_grow(input logic [NS-1:0] en);
        return {en[NS-2:0], 1'b1};
    endfunction

    // Watch enable order, reset release and shutdown pulse
    always @(negedge sys_clk) begin
        if (rstn) begin
            if (supply_en !== sup_prev && supply_en !== '0) chk("supply_en order", 32'(exp_grow(sup_prev)), 32'(supply_en));
            if (secondary_reset_output === 1'b1 && rso_prev !== 1'b1) chk("supply_en at release", 32'({NS{1'b1}}), 32'(supply_en));
            if (powered_down === 1'b1 && pd_prev !== 1'b1) chk("shutdown_pulse", 32'h1, 32'(shutdown_pulse));
            if (shutdown_pulse === 1'b1) chk("pulse width", 32'h0, 32'(sp_prev));
        end
        sup_prev = supply_en;
        pd_prev = powered_down;
        rso_prev = secondary_reset_output;
        sp_prev = shutdown_pulse;
    end

    function automatic int rnd(input int lo, input int hi);
        lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
        return lo + int'(lfsr_reg % 32'(hi - lo + 1));
    endfunction

    function automatic logic pick(input int sel);
        case (sel)
            0: return secondary_reset_output;
            1: return phone_active;
            2: return tog_done;
            3: return powered_down;
            default: return ~powered_down;
        endcase
    endfunction

    task automatic wait_for(input int sel, input int lim, output int n);
        n = 0;
        while (pick(sel) !== 1'b1 && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic expect_down(input string what, input int lo, input int hi);
        int n;
        wait_for(3, hi + 1, n);
        checked++;
        if (n < lo || n > hi) begin
            num_errors++;
            $display("ERROR %s power down after %0d..%0d cycles seen %0d", what, lo, hi, n);
        end
        $display("test %s done", what);
    endtask

    // Source 0 key fall, 1 aux rise, 2 charger rise, 3 fuses done
    task automatic trig(input int src);
        repeat (6) @(negedge sys_clk);
        if (src == 3) begin
            fuses = 1'b1;
        end else begin
            pins[src] = (src == 0);
            repeat (4) @(negedge sys_clk);
            pins[src] = (src != 0);
        end
    endtask

    task automatic go(input string what, input int src, input int fg, input int gp, input int n,
                      input logic erl, input logic ff, input int lo, input int hi);
        int k;
        first_gap = fg;
        gap = gp;
        n_tog = n;
        early = erl;
        fall_first = ff;
        trig(src);
        wait_for(0, 80, k);
        chk({what, " reset release"}, 32'h1, 32'(secondary_reset_output));
        if (n > 0 && !ff) begin
            wait_for(1, fg + 10, k);
            chk({what, " phone_active"}, 32'h1, 32'(phone_active));
        end
        if (hi > 0) begin
            @(negedge sys_clk);
            wait_for(2, 2000, k);
            chk({what, " toggles done"}, 32'h1, 32'(tog_done));
            expect_down(what, lo, hi);
        end
    endtask

    initial begin
        int fg;
        int gp;
        int n;
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (20) @(negedge sys_clk);
        chk("powered_down", 32'h1, 32'(powered_down));
        chk("ref_osc_en", 32'h1, 32'(ref_osc_en));
        chk("fuse_read", 32'h1, 32'(fuse_read));
        chk("supply_en idle", 32'h0, 32'(supply_en));
        fg = rnd(5, 150);
        gp = rnd(MIN + 2, MAX - 2);
        n = rnd(2, 5);
        go("charger level", 3, fg, gp, n, 1'b0, 1'b0, MAX - 1, MAX + 8);
        chk("fuse_read done", 32'h0, 32'(fuse_read));
        go("key early edge", 0, 10, MAX - 2, 4, 1'b1, 1'b0, 1, 8);
        go("aux fall first", 1, 30, MIN + 2, 1, 1'b0, 1'b1, 1, 8);
        go("charger edge no rise", 2, 0, 0, 0, 1'b0, 1'b0, RESP - 2, RESP + 8);
        go("aux min gap", 1, 40, MIN + 2, 4, 1'b0, 1'b0, MAX - 1, MAX + 8);
        for (int i = 0; i < 2; i++) begin
            go("supply drop", 1, 10, MIN + 5, 50, 1'b0, 1'b0, 0, 0);
            if (i == 0) por_low = 1'b1;
            else ov = 1'b1;
            @(negedge sys_clk);
            por_low = 1'b0;
            ov = 1'b0;
            expect_down("drop in active", 0, 4);
        end
        good_mask = 4'h4;
        trig(0);
        wait_for(4, 10, n);
        chk("seq start", 32'h0, 32'(powered_down));
        expect_down("block not good", STEP, STEP + 15);
        good_mask = '0;
        uv = 1'b1;
        trig(0);
        wait_for(4, 10, n);
        chk("seq start uv", 32'h0, 32'(powered_down));
        expect_down("undervoltage", 0, 3);
        uv = 1'b0;
        results();
    end
endmodule
